//--- sps_page_mux.sv
`timescale 1ns/10ps
package sps_pkg;
   localparam int unsigned PAGE_W    = 3;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned SRAM_AW   = PAGE_W + ADDR_W;
   localparam int unsigned PAGE_SIZE = 256;
   localparam int unsigned NUM_PAGES = 8;
   // Paging-mode bits inside the flag register
   localparam int unsigned MODE_HI   = 7;
   localparam int unsigned MODE_LO   = 6;
   // Register offsets
   localparam logic [7:0] OFF_CUR    = 8'hD0;
   localparam logic [7:0] OFF_STK    = 8'hD1;
   localparam logic [7:0] OFF_IDX    = 8'hD3;
   localparam logic [7:0] OFF_MVR    = 8'hD4;
   localparam logic [7:0] OFF_MVW    = 8'hD5;
   localparam logic [7:0] OFF_SP     = 8'hF6;
   localparam logic [7:0] OFF_FLAG   = 8'hF7;
   // Values after reset, page zero and paging-mode encodings
   localparam logic [2:0] PAGE_RST   = 3'h0;
   localparam logic [7:0] FLAG_RST   = 8'h00;
   localparam logic [7:0] SP_RST     = 8'h00;
   localparam logic [7:0] RDATA_RST  = 8'h00;
   localparam logic [2:0] PAGE_ZERO  = 3'h0;
   localparam logic [1:0] MODE_OFF   = 2'h0;
   localparam logic [1:0] MODE_STKX  = 2'h1;
   localparam logic [1:0] MODE_IDX   = 2'h2;
   localparam logic [1:0] MODE_CURST = 2'h3;
   // Cycles of one post-increment move
   localparam int unsigned MVI_CYCLES = 3;

   typedef enum logic [2:0] {
      ACC_NORMAL  = 3'h0,
      ACC_STACK   = 3'h1,
      ACC_INDEXED = 3'h2,
      ACC_MVI_PTR = 3'h3,
      ACC_MVI_RD  = 3'h4,
      ACC_MVI_WR  = 3'h5
   } sps_acc_t;

   typedef enum logic [1:0] {
      MV_IDLE   = 2'b00,
      MV_PTR_RD = 2'b01,
      MV_PTR_WR = 2'b11,
      MV_DATA   = 2'b10
   } sps_mv_state_t;
endpackage

module sps_page_mux (
   input  wire sps_pkg::sps_acc_t acc_type,
   input  wire logic [1:0]        mode,
   input  wire logic [2:0]        cur_page,
   input  wire logic [2:0]        stk_page,
   input  wire logic [2:0]        idx_page,
   input  wire logic [2:0]        mvr_page,
   input  wire logic [2:0]        mvw_page,
   output logic      [2:0]        page
);
   logic [2:0] normal_page;

   always_comb begin
      // [R3] [R4] Flag bit 7 enables paging
      // [R16] Upper mode bit gates current page
      normal_page = mode[1] ? cur_page : sps_pkg::PAGE_ZERO;
      page        = normal_page;
      unique case (acc_type)
         // [R5] [R6] Stack page always
         sps_pkg::ACC_STACK:   page = stk_page;
         // [R17] Indexed paging by mode
         sps_pkg::ACC_INDEXED: begin
            unique case (mode)
               sps_pkg::MODE_OFF:   page = sps_pkg::PAGE_ZERO;
               sps_pkg::MODE_STKX:  page = stk_page;
               sps_pkg::MODE_IDX:   page = idx_page;
               sps_pkg::MODE_CURST: page = stk_page;
            endcase
         end
         // [R14] Move page pointers
         sps_pkg::ACC_MVI_RD:  page = mvr_page;
         sps_pkg::ACC_MVI_WR:  page = mvw_page;
         default:              page = normal_page;
      endcase
   end
endmodule

//--- sps_page_select.sv
// What this block does
// [R1] Page number widens 8-bit CPU address to eight 256-byte pages.
// [R2] Reset clears all page pointers and paging-mode bits.
// [R3] Paged normal access only while flag bit 7 set.
// [R4] Unpaged mode sends every normal access to page 0.
// [R5] Stack and post-increment moves ignore current page pointer; the move's pointer read and write use it when paged.
// [R6] Stack accesses use stack page pointer, regardless of mode bits.
// [R7] Call, return, pop leave paging mode of other accesses unchanged.
// [R8] Stack pointer wraps within its page, never carries into page.
// [R9] Software sets stack page once, before first stack use.
// [R10] Interrupt entry pushes flag register then clears it.
// [R11] Return from interrupt restores the pushed flag value.
// [R12] Interrupt routines save and restore page pointers they change.
// [R13] Post-increment move: read pointer, write pointer+1, then data access.
// [R14] Read move uses read page, write move uses write page.
// [R15] Move page pointers apply whatever the mode bits hold.
// [R16] Upper mode bit selects page 0 or current page pointer.
// [R17] Indexed: 00 page 0, 01 stack, 10 index, 11 stack.
// [R18] Current page pointer bits 2:0, read-write, reset zero.
// [R19] Physical address is page above 8-bit address, eleven bits.
// [R20] Page chosen combinationally, pointer writes affect next access.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
module sps_page_select (
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   input  wire logic                   flag_wr,
   input  wire logic [7:0]             flag_wdata,
   output logic      [7:0]             flag_out,
   input  wire logic                   irq_entry,
   output logic      [7:0]             flag_push_data,
   input  wire logic                   return_from_interrupt,
   input  wire logic [7:0]             flag_pop_data,
   input  wire logic                   sp_inc,
   input  wire logic                   sp_dec,
   output logic      [7:0]             sp_out,
   input  wire sps_pkg::sps_acc_t      acc_type,
   input  wire logic [7:0]             acc_addr,
   input  wire logic                   acc_we,
   input  wire logic [7:0]             acc_wdata,
   input  wire logic                   mvi_start,
   input  wire logic                   mvi_dir,
   input  wire logic [7:0]             mvi_ptr_addr,
   input  wire logic [7:0]             mvi_acc_data,
   output logic                        mvi_busy,
   output logic      [10:0]            sram_addr,
   output logic                        sram_we,
   output logic      [7:0]             sram_wdata,
   input  wire logic [7:0]             sram_rdata
);
   logic [2:0]                cur_reg, cur_next;
   logic [2:0]                stk_reg, stk_next;
   logic [2:0]                idx_reg, idx_next;
   logic [2:0]                mvr_reg, mvr_next;
   logic [2:0]                mvw_reg, mvw_next;
   logic [7:0]                flag_reg, flag_next;
   logic [7:0]                sp_reg, sp_next;
   logic [7:0]                rdata_reg, rdata_next;
   sps_pkg::sps_mv_state_t    mv_reg, mv_next;
   logic                      dir_reg, dir_next;
   logic [7:0]                ptr_reg, ptr_next;
   logic [7:0]                ploc_reg, ploc_next;
   sps_pkg::sps_acc_t         eff_type;
   logic [7:0]                eff_addr;
   logic [2:0]                page;
   logic [1:0]                mode;

   assign mode           = flag_reg[sps_pkg::MODE_HI:sps_pkg::MODE_LO];
   // [R10] Value pushed on interrupt entry
   assign flag_push_data = flag_reg;
   assign flag_out       = flag_reg;
   assign sp_out         = sp_reg;
   assign reg_rdata      = rdata_reg;
   assign mvi_busy       = (mv_reg != sps_pkg::MV_IDLE);

   // Page pointer registers and bus read data
   always_comb begin
      cur_next   = cur_reg;
      stk_next   = stk_reg;
      idx_next   = idx_reg;
      mvr_next   = mvr_reg;
      mvw_next   = mvw_reg;
      rdata_next = sps_pkg::RDATA_RST;
      // [R18] Pointer writes, low three bits
      if (reg_wr) begin
         unique case (reg_addr)
            sps_pkg::OFF_CUR: cur_next = reg_wdata[2:0];
            sps_pkg::OFF_STK: stk_next = reg_wdata[2:0];
            sps_pkg::OFF_IDX: idx_next = reg_wdata[2:0];
            sps_pkg::OFF_MVR: mvr_next = reg_wdata[2:0];
            sps_pkg::OFF_MVW: mvw_next = reg_wdata[2:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            sps_pkg::OFF_CUR:  rdata_next = {5'h00, cur_reg};
            sps_pkg::OFF_STK:  rdata_next = {5'h00, stk_reg};
            sps_pkg::OFF_IDX:  rdata_next = {5'h00, idx_reg};
            sps_pkg::OFF_MVR:  rdata_next = {5'h00, mvr_reg};
            sps_pkg::OFF_MVW:  rdata_next = {5'h00, mvw_reg};
            sps_pkg::OFF_SP:   rdata_next = sp_reg;
            sps_pkg::OFF_FLAG: rdata_next = flag_reg;
            default:           rdata_next = sps_pkg::RDATA_RST;
         endcase
      end
   end

   // [R2] Reset clears all paging state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur_reg   <= sps_pkg::PAGE_RST;
         stk_reg   <= sps_pkg::PAGE_RST;
         idx_reg   <= sps_pkg::PAGE_RST;
         mvr_reg   <= sps_pkg::PAGE_RST;
         mvw_reg   <= sps_pkg::PAGE_RST;
         rdata_reg <= sps_pkg::RDATA_RST;
      end else begin
         cur_reg   <= cur_next;
         stk_reg   <= stk_next;
         idx_reg   <= idx_next;
         mvr_reg   <= mvr_next;
         mvw_reg   <= mvw_next;
         rdata_reg <= rdata_next;
      end
   end

   // Flag register and stack pointer
   always_comb begin
      flag_next = flag_reg;
      sp_next   = sp_reg;
      // [R10] Entry clears flags, wins over all
      if (irq_entry) begin
         flag_next = sps_pkg::FLAG_RST;
      // [R11] Restore pushed flags
      end else if (return_from_interrupt) begin
         flag_next = flag_pop_data;
      end else if (flag_wr) begin
         flag_next = flag_wdata;
      end
      // [R8] Eight-bit wrap, no page carry
      if (sp_inc && !sp_dec) begin
         sp_next = sp_reg + 8'h01;
      end else if (sp_dec && !sp_inc) begin
         sp_next = sp_reg - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flag_reg <= sps_pkg::FLAG_RST;
         sp_reg   <= sps_pkg::SP_RST;
      end else begin
         flag_reg <= flag_next;
         sp_reg   <= sp_next;
      end
   end

   // Post-increment move sequencer
   always_comb begin
      mv_next   = mv_reg;
      dir_next  = dir_reg;
      ptr_next  = ptr_reg;
      ploc_next = ploc_reg;
      // [R13] Three accesses in order
      unique case (mv_reg)
         sps_pkg::MV_IDLE: begin
            if (mvi_start) begin
               mv_next   = sps_pkg::MV_PTR_RD;
               dir_next  = mvi_dir;
               ploc_next = mvi_ptr_addr;
            end
         end
         sps_pkg::MV_PTR_RD: mv_next = sps_pkg::MV_PTR_WR;
         sps_pkg::MV_PTR_WR: begin
            mv_next  = sps_pkg::MV_DATA;
            ptr_next = sram_rdata;
         end
         sps_pkg::MV_DATA:   mv_next = sps_pkg::MV_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mv_reg   <= sps_pkg::MV_IDLE;
         dir_reg  <= 1'b0;
         ptr_reg  <= 8'h00;
         ploc_reg <= 8'h00;
      end else begin
         mv_reg   <= mv_next;
         dir_reg  <= dir_next;
         ptr_reg  <= ptr_next;
         ploc_reg <= ploc_next;
      end
   end

   // Access steering
   always_comb begin
      eff_type   = acc_type;
      eff_addr   = acc_addr;
      sram_we    = acc_we;
      sram_wdata = acc_wdata;
      unique case (mv_reg)
         sps_pkg::MV_IDLE: begin
            // [R6] [R7] Stack low byte from pointer
            if (acc_type == sps_pkg::ACC_STACK) begin
               eff_addr = sp_reg;
            end
         end
         // [R13] Pointer lives in normal-access page
         sps_pkg::MV_PTR_RD: begin
            eff_type = sps_pkg::ACC_MVI_PTR;
            eff_addr = ploc_reg;
            sram_we  = 1'b0;
         end
         sps_pkg::MV_PTR_WR: begin
            eff_type   = sps_pkg::ACC_MVI_PTR;
            eff_addr   = ploc_reg;
            sram_we    = 1'b1;
            sram_wdata = sram_rdata + 8'h01;
         end
         // [R15] Move pages regardless of mode
         sps_pkg::MV_DATA: begin
            eff_type   = dir_reg ? sps_pkg::ACC_MVI_WR : sps_pkg::ACC_MVI_RD;
            eff_addr   = ptr_reg;
            sram_we    = dir_reg;
            sram_wdata = mvi_acc_data;
         end
      endcase
   end

   // [R20] Combinational page choice
   sps_page_mux u_mux (
      .acc_type (eff_type),
      .mode     (mode),
      .cur_page (cur_reg),
      .stk_page (stk_reg),
      .idx_page (idx_reg),
      .mvr_page (mvr_reg),
      .mvw_page (mvw_reg),
      .page     (page)
   );

   // [R1] [R19] Page above byte address
   assign sram_addr = {page, eff_addr};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_mv_steps;
      mv_reg == sps_pkg::MV_PTR_RD ##1 mv_reg == sps_pkg::MV_PTR_WR ##1
      mv_reg == sps_pkg::MV_DATA ##1 mv_reg == sps_pkg::MV_IDLE;
   endsequence

   a_mvi_three_steps: assert property ( // [R13]
      (mv_reg == sps_pkg::MV_IDLE && mvi_start) |=> s_mv_steps)
      else $error("Move did not take three accesses");

   a_mvi_ptr_inc: assert property ( // [R13]
      mv_reg == sps_pkg::MV_PTR_WR |-> sram_we && sram_wdata == sram_rdata + 8'h01
      && sram_addr[7:0] == ploc_reg && sram_addr[10:8] == (mode[1] ? cur_reg : 3'h0))
      else $error("Pointer write-back wrong");

   a_mvi_data_page: assert property ( // [R14]
      mv_reg == sps_pkg::MV_DATA |-> sram_addr[10:8] == (dir_reg ? mvw_reg : mvr_reg)
      && sram_we == dir_reg)
      else $error("Move data page wrong");

   a_stack_page: assert property ( // [R6]
      (mv_reg == sps_pkg::MV_IDLE && acc_type == sps_pkg::ACC_STACK)
      |-> sram_addr == {stk_reg, sp_reg})
      else $error("Stack access left stack page");

   a_normal_unpaged: assert property ( // [R4]
      (mv_reg == sps_pkg::MV_IDLE && acc_type == sps_pkg::ACC_NORMAL)
      |-> sram_addr[10:8] == (flag_reg[7] ? cur_reg : 3'h0))
      else $error("Normal access page wrong");

   a_index_mode: assert property ( // [R17]
      (mv_reg == sps_pkg::MV_IDLE && acc_type == sps_pkg::ACC_INDEXED)
      |-> sram_addr[10:8] == (mode == 2'h2 ? idx_reg : (mode == 2'h0 ? 3'h0 : stk_reg)))
      else $error("Indexed access page wrong");

   a_irq_clear: assert property ( // [R10]
      irq_entry |-> flag_push_data == flag_reg ##1 flag_reg == 8'h00)
      else $error("Flags not pushed and cleared");

   a_return_from_interrupt_restore: assert property ( // [R11]
      (return_from_interrupt && !irq_entry) |=> flag_reg == $past(flag_pop_data))
      else $error("Flags not restored");

   a_sp_wrap: assert property ( // [R8]
      (sp_dec && !sp_inc && sp_reg == 8'h00) |=> sp_reg == 8'hFF && $stable(stk_reg))
      else $error("Stack pointer did not wrap");

   a_cur_write: assert property ( // [R18]
      (reg_wr && reg_addr == sps_pkg::OFF_CUR) ##1 (reg_rd && reg_addr == sps_pkg::OFF_CUR)
      |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)})
      else $error("Current page readback wrong");
endmodule

//--- sps_sram_model.sv
`timescale 1ns/10ps
module sps_sram_model (
   input  wire logic        clk,
   input  wire logic [10:0] sram_addr,
   input  wire logic        sram_we,
   input  wire logic [7:0]  sram_wdata,
   output logic      [7:0]  sram_rdata
);
   logic [7:0] mem [2048];

   always @(posedge clk) begin
      if (sram_we) begin
         mem[sram_addr] <= sram_wdata;
      end
      sram_rdata <= mem[sram_addr];
   end
endmodule

//--- sps_page_select_tb.sv
`timescale 1ns/10ps
module sps_page_select_tb;
   logic              clk, resetn, reg_wr, reg_rd, flag_wr, irq_entry, return_from_interrupt;
   logic              sp_inc, sp_dec, acc_we, mvi_start, mvi_dir, mvi_busy, sram_we;
   logic [7:0]        reg_addr, reg_wdata, reg_rdata, flag_wdata, flag_out;
   logic [7:0]        flag_push_data, flag_pop_data, sp_out, acc_addr, acc_wdata;
   logic [7:0]        mvi_ptr_addr, mvi_acc_data, sram_wdata, sram_rdata;
   logic [10:0]       sram_addr;
   sps_pkg::sps_acc_t acc_type;
   int                bad_count = 0;
   int                n_tests = 0;
   localparam logic [7:0] OFFS [7] = '{sps_pkg::OFF_CUR, sps_pkg::OFF_STK,
      sps_pkg::OFF_IDX, sps_pkg::OFF_MVR, sps_pkg::OFF_MVW, sps_pkg::OFF_SP,
      sps_pkg::OFF_FLAG};
   localparam logic [2:0] IX [4] = '{3'h0, 3'h2, 3'h3, 3'h2};

   sps_page_select dut_u (
      .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .flag_wr, .flag_wdata, .flag_out, .irq_entry, .flag_push_data, .return_from_interrupt,
      .flag_pop_data, .sp_inc, .sp_dec, .sp_out, .acc_type, .acc_addr,
      .acc_we, .acc_wdata, .mvi_start, .mvi_dir, .mvi_ptr_addr,
      .mvi_acc_data, .mvi_busy, .sram_addr, .sram_we, .sram_wdata, .sram_rdata
   );
   sps_sram_model mem_u (.clk, .sram_addr, .sram_we, .sram_wdata, .sram_rdata);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk({3'h0, reg_rdata}, {3'h0, e});
   endtask

   task automatic fl(input logic [7:0] v);
      @(posedge clk);
      flag_wdata <= v;
      flag_wr    <= 1'b1;
      @(posedge clk);
      flag_wr    <= 1'b0;
   endtask

   // Stack byte comes from sp, so acc_addr is made to differ
   task automatic acc(input sps_pkg::sps_acc_t t, input logic [10:0] e);
      @(posedge clk);
      acc_type <= t;
      acc_addr <= (t == sps_pkg::ACC_STACK) ? ~e[7:0] : e[7:0];
      #1;
      chk(sram_addr, e);
   endtask

   task automatic t_reset;
      for (int i = 0; i < 7; i++) begin
         rd(OFFS[i], 8'h00);
      end
      acc(sps_pkg::ACC_NORMAL, 11'h0A5);
      acc(sps_pkg::ACC_STACK, 11'h000);
      $display("test reset done");
   endtask

   task automatic t_regs;
      // Stack page set before stack use
      for (int i = 0; i < 5; i++) begin
         wr(OFFS[i], 8'hF8 | 8'(i + 1));
      end
      for (int i = 0; i < 5; i++) begin
         rd(OFFS[i], 8'(i + 1));
      end
      wr(sps_pkg::OFF_SP, 8'h33);
      rd(sps_pkg::OFF_SP, 8'h00);
      rd(8'h00, 8'h00);
      // Write then read with no gap
      @(posedge clk);
      reg_addr  <= sps_pkg::OFF_CUR;
      reg_wdata <= 8'hF9;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1;
      chk({3'h0, reg_rdata}, 11'h001);
      $display("test registers done");
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         fl({m[1:0], 6'h00});
         acc(sps_pkg::ACC_NORMAL, {m[1] ? 3'h1 : 3'h0, 8'h3C});
         acc(sps_pkg::ACC_INDEXED, {IX[m], 8'h3C});
         acc(sps_pkg::ACC_STACK, {3'h2, 8'h00});
      end
      wr(sps_pkg::OFF_CUR, 8'h06);
      acc(sps_pkg::ACC_NORMAL, {3'h6, 8'h3C});
      $display("test modes done");
   endtask

   task automatic t_sp;
      @(posedge clk);
      sp_dec <= 1'b1;
      @(posedge clk);
      sp_dec <= 1'b0;
      #1;
      chk({3'h0, sp_out}, 11'h0FF);
      acc(sps_pkg::ACC_STACK, {3'h2, 8'hFF});
      acc(sps_pkg::ACC_NORMAL, {3'h6, 8'h11});
      @(posedge clk);
      sp_inc <= 1'b1;
      @(posedge clk);
      sp_inc <= 1'b0;
      #1;
      chk({3'h0, sp_out}, 11'h000);
      $display("test stack pointer done");
   endtask

   task automatic t_irq;
      fl(8'hC0);
      @(posedge clk);
      irq_entry <= 1'b1;
      #1;
      chk({3'h0, flag_push_data}, 11'h0C0);
      @(posedge clk);
      irq_entry <= 1'b0;
      #1;
      chk({3'h0, flag_out}, 11'h000);
      acc(sps_pkg::ACC_NORMAL, {3'h0, 8'h22});
      fl(8'h40);
      @(posedge clk);
      return_from_interrupt          <= 1'b1;
      flag_pop_data <= 8'hC0;
      @(posedge clk);
      return_from_interrupt          <= 1'b0;
      #1;
      chk({3'h0, flag_out}, 11'h0C0);
      acc(sps_pkg::ACC_NORMAL, {3'h6, 8'h22});
      $display("test interrupt done");
   endtask

   task automatic t_mvi(input logic d, input logic [2:0] pg, input logic [7:0] p);
      @(posedge clk);
      mvi_dir   <= d;
      mvi_start <= 1'b1;
      @(posedge clk);
      mvi_start <= 1'b0;
      #1;
      chk(sram_addr, {3'h6, 8'h20});
      chk({10'h0, sram_we}, 11'h000);
      @(posedge clk);
      #1;
      chk(sram_addr, {3'h6, 8'h20});
      chk({2'h0, sram_we, sram_wdata}, {3'h1, p + 8'h01});
      @(posedge clk);
      #1;
      chk(sram_addr, {pg, p});
      chk({9'h0, mvi_busy, sram_we}, {9'h1, d});
      if (d) begin
         chk({3'h0, sram_wdata}, 11'h0A5);
      end
      @(posedge clk);
      #1;
      chk({10'h0, mvi_busy}, 11'h000);
   endtask

   task automatic t_moves;
      @(posedge clk);
      acc_type  <= sps_pkg::ACC_NORMAL;
      acc_addr  <= 8'h20;
      acc_wdata <= 8'h40;
      acc_we    <= 1'b1;
      @(posedge clk);
      acc_we    <= 1'b0;
      t_mvi(1'b0, 3'h4, 8'h40);
      t_mvi(1'b1, 3'h5, 8'h41);
      $display("test moves done");
   endtask

   // Hang guard
   initial begin
      #1000000;
      bad_count++;
      end_of_test();
   end

   initial begin
      resetn        = 1'b0;
      reg_addr      = 8'h00;
      reg_wdata     = 8'h00;
      reg_wr        = 1'b0;
      reg_rd        = 1'b0;
      flag_wr       = 1'b0;
      flag_wdata    = 8'h00;
      irq_entry     = 1'b0;
      return_from_interrupt          = 1'b0;
      flag_pop_data = 8'h00;
      sp_inc        = 1'b0;
      sp_dec        = 1'b0;
      acc_type      = sps_pkg::ACC_NORMAL;
      acc_addr      = 8'h00;
      acc_we        = 1'b0;
      acc_wdata     = 8'h00;
      mvi_start     = 1'b0;
      mvi_dir       = 1'b0;
      mvi_ptr_addr  = 8'h20;
      mvi_acc_data  = 8'hA5;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_regs();
      t_modes();
      t_sp();
      t_irq();
      t_moves();
      end_of_test();
   end
endmodule
